// file: pkg/fpp_pkg.sv
package fpp_pkg;
  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned SETUP_WAIT_NS  = 10000;
  localparam int unsigned SETUP_CYCLES   = (SETUP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W          = 8;

  // Array geometry
  localparam int unsigned USER_BYTES     = 12288;
  localparam int unsigned VECT_BYTES     = 48;
  localparam int unsigned ARRAY_BYTES    = USER_BYTES + VECT_BYTES;
  localparam int unsigned IDX_W          = 14;
  localparam logic [15:0] USER_BASE      = 16'hc000;
  localparam logic [15:0] USER_LAST      = 16'hefff;
  localparam logic [15:0] VECT_BASE      = 16'hffd0;
  localparam logic [15:0] VECT_LAST      = 16'hffff;
  localparam int unsigned PAGE_SHIFT     = 7;
  localparam int unsigned PAGE_BYTES     = 128;
  localparam int unsigned ROW_BYTES      = 64;
  localparam int unsigned ROW_SHIFT      = 6;

  // Register addresses
  localparam logic [15:0] ADDR_OP_CONTROL    = 16'hfe08;
  localparam logic [15:0] ADDR_PROTECT_START = 16'hfe09;

  // Control register fields
  localparam int unsigned BIT_WRITE_SELECT   = 0;
  localparam int unsigned BIT_ERASE_SELECT   = 1;
  localparam int unsigned BIT_MASS_SELECT    = 2;
  localparam int unsigned BIT_HIGH_VOLTAGE   = 3;

  // Reset values and constants
  localparam logic [7:0]  OP_CONTROL_RESET   = 8'h00;
  localparam logic [7:0]  PROTECT_RESET      = 8'hff;
  localparam logic [7:0]  PROTECT_NONE       = 8'hff;
  localparam logic [7:0]  ERASED_BYTE        = 8'hff;
  localparam logic [1:0]  PROTECT_HIGH_BITS  = 2'b11;
  localparam logic [6:0]  PROTECT_LOW_BITS   = 7'h00;

  typedef enum logic [2:0] {
    FPP_IDLE,
    FPP_ARMED,
    FPP_SETUP,
    FPP_READY,
    FPP_SWEEP,
    FPP_ACTIVE
  } fpp_state_t;
endpackage

// file: core/fpp_flash_ctrl.sv
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
// Overview of operation
// - Erased bits read one, programmed bits zero
// - User array C000-EFFF, vectors FFD0-FFFF
// - Page erase covers 128 aligned bytes
// - High voltage only after select and order
// - High voltage drives pump and array supply
// - Mass bit picks whole array or page
// - Program and erase selects never both set
// - Page erase never clears vector page
// - Program select latches write address, data
// - Programming works on 64-byte rows
// - Protected target refuses high voltage
// - Protect start from bits 7..1
// - All ones disables, zeros protect all
module fpp_flash_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [7:0]  bus_rdata,
  output logic             pump_on,
  output logic             array_hv_on
);

  // Sequencer states:
  //   idle   - no select, flash writes ignored
  //   armed  - select set, waiting for the target write
  //   setup  - target latched, setup wait counting down
  //   ready  - setup wait over, high voltage may be set
  //   sweep  - erase in progress, one byte per clock
  //   active - high voltage on, program writes land
  // Timing after the setup wait is not checked: a short program wait still works here
  // Block state apart from the byte array in one register, filled by one process
  typedef struct packed {
    logic                        write_select;
    logic                        erase_select;
    logic                        mass_select;
    logic                        high_voltage_on;
    logic [7:0]                  protect_start_bits;
    logic [15:0]                 target_addr;
    logic [7:0]                  target_data;
    logic [fpp_pkg::CNT_W-1:0]   setup_cnt;
    logic [fpp_pkg::IDX_W-1:0]   sweep_cnt;
    logic [7:0]                  rdata;
    logic                        pump;
    logic                        hv;
    fpp_pkg::fpp_state_t         st;
  } fpp_regs_t;

  fpp_regs_t r;
  fpp_regs_t next_r;

  // Byte storage; kept out of the struct so it maps onto a RAM
  logic [7:0] mem [fpp_pkg::ARRAY_BYTES];

  logic                      mem_we;
  logic [fpp_pkg::IDX_W-1:0] mem_idx;
  logic [7:0]                mem_wd;

  // Array index of a CPU address; bit IDX_W flags a hit
  // User bytes come first, vectors follow them in the store
  // Addresses between the two ranges miss and are never written
  function automatic logic [fpp_pkg::IDX_W:0] flash_index(input logic [15:0] a);
    logic [15:0] off;
    off = '0;
    if (a >= fpp_pkg::USER_BASE && a <= fpp_pkg::USER_LAST) begin
      off = a - fpp_pkg::USER_BASE;
      return {1'b1, off[fpp_pkg::IDX_W-1:0]};
    end
    if (a >= fpp_pkg::VECT_BASE) begin
      off = a - fpp_pkg::VECT_BASE + 16'(fpp_pkg::USER_BYTES);
      return {1'b1, off[fpp_pkg::IDX_W-1:0]};
    end
    return '0;
  endfunction

  // Protect start address and hit test
  function automatic logic is_protected(input logic [7:0] p, input logic [15:0] a);
    logic [15:0] start;
    start = {fpp_pkg::PROTECT_HIGH_BITS, p[7:1], fpp_pkg::PROTECT_LOW_BITS};
    if (p == fpp_pkg::PROTECT_NONE) begin
      return 1'b0;
    end
    return a >= start;
  endfunction

  // Readback image of the control register; unused bits read zero
  function automatic logic [7:0] ctl_image(
    input logic ws,
    input logic es,
    input logic ms,
    input logic hv
  );
    logic [7:0] img;
    img                            = '0;
    img[fpp_pkg::BIT_WRITE_SELECT] = ws;
    img[fpp_pkg::BIT_ERASE_SELECT] = es;
    img[fpp_pkg::BIT_MASS_SELECT]  = ms;
    img[fpp_pkg::BIT_HIGH_VOLTAGE] = hv;
    return img;
  endfunction

  // Row match on the upper address bits; programming never leaves the row
  function automatic logic same_row(input logic [15:0] a, input logic [15:0] b);
    return a[15:fpp_pkg::ROW_SHIFT] == b[15:fpp_pkg::ROW_SHIFT];
  endfunction

  // Last index of a sweep: the whole array, or one page
  function automatic logic sweep_last(input logic mass, input logic [fpp_pkg::IDX_W-1:0] cnt);
    if (mass) begin
      return cnt == fpp_pkg::IDX_W'(fpp_pkg::ARRAY_BYTES - 1);
    end
    return cnt == fpp_pkg::IDX_W'(fpp_pkg::PAGE_BYTES - 1);
  endfunction

  // High voltage may rise only from ready, with one select and an open target
  function automatic logic hv_allowed(
    input fpp_pkg::fpp_state_t st,
    input logic                one_sel,
    input logic                hv_now,
    input logic [7:0]          prot,
    input logic [15:0]         target
  );
    if (hv_now || st != fpp_pkg::FPP_READY || !one_sel) begin
      return 1'b0;
    end
    return !is_protected(prot, target);
  endfunction

  logic [fpp_pkg::IDX_W:0] bus_hit;
  logic [fpp_pkg::IDX_W:0] page_hit;
  logic [15:0]             page_addr;
  logic                    hv_req;
  logic                    sel_ok;
  // Bus decode, shared by the sequencer branches
  logic                    ctl_wr;
  logic                    prot_wr;
  logic                    arr_wr;

  // Limitations worth knowing:
  //   erase and program take effect at once, not after the pump time
  //   a page erase aimed at the vector page changes nothing
  //   protection is judged when high voltage is set, against the latched target
  //   flash writes during a sweep are dropped, not queued
  //   reads during a sweep see the bytes as far as it has got
  // Sequencer, register file and array port
  always_comb begin
    next_r    = r;
    mem_we    = 1'b0;
    mem_idx   = '0;
    mem_wd    = fpp_pkg::ERASED_BYTE;
    bus_hit   = flash_index(bus_addr);
    page_addr = {r.target_addr[15:fpp_pkg::PAGE_SHIFT], r.sweep_cnt[fpp_pkg::PAGE_SHIFT-1:0]};
    page_hit  = flash_index(page_addr);
    hv_req    = bus_wdata[fpp_pkg::BIT_HIGH_VOLTAGE];
    sel_ok    = r.write_select ^ r.erase_select;
    ctl_wr    = bus_wr && bus_addr == fpp_pkg::ADDR_OP_CONTROL;
    prot_wr   = bus_wr && bus_addr == fpp_pkg::ADDR_PROTECT_START;
    arr_wr    = bus_wr && bus_hit[fpp_pkg::IDX_W];

    // Read path: one cycle of latency, unmapped reads zero
    next_r.rdata = '0;
    if (bus_rd) begin
      if (bus_addr == fpp_pkg::ADDR_OP_CONTROL) begin
        next_r.rdata = ctl_image(r.write_select, r.erase_select, r.mass_select,
                                 r.high_voltage_on);
      end else if (bus_addr == fpp_pkg::ADDR_PROTECT_START) begin
        next_r.rdata = r.protect_start_bits;
      end else if (bus_hit[fpp_pkg::IDX_W]) begin
        next_r.rdata = mem[bus_hit[fpp_pkg::IDX_W-1:0]];
      end
    end

    // Setup wait counts down before high voltage may rise
    if (r.st == fpp_pkg::FPP_SETUP) begin
      if (r.setup_cnt == '0) begin
        next_r.st = fpp_pkg::FPP_READY;
      end else begin
        next_r.setup_cnt = r.setup_cnt - 1'b1;
      end
    end

    // Erase sweep, one byte per cycle; bus writes to the array are dropped until it ends
    if (r.st == fpp_pkg::FPP_SWEEP) begin
      if (r.mass_select) begin
        mem_we  = 1'b1;
        mem_idx = r.sweep_cnt;
        // Vectors are included: mass erase is their only way back to ones
        if (sweep_last(r.mass_select, r.sweep_cnt)) begin
          next_r.st = fpp_pkg::FPP_ACTIVE;
        end
      end else begin
        // Vector page is skipped: only mass erase may clear it
        mem_we  = page_hit[fpp_pkg::IDX_W] && (page_addr < fpp_pkg::VECT_BASE);
        mem_idx = page_hit[fpp_pkg::IDX_W-1:0];
        // Low bits of the counter walk the page of the latched target
        if (sweep_last(r.mass_select, r.sweep_cnt)) begin
          next_r.st = fpp_pkg::FPP_ACTIVE;
        end
      end
      next_r.sweep_cnt = r.sweep_cnt + 1'b1;
    end

    // Register writes
    // Bit 3 clears on any control write without it; set needs the interlocks
    if (ctl_wr) begin
      // A write that sets both selects leaves them unchanged
      if (!(bus_wdata[fpp_pkg::BIT_WRITE_SELECT] && bus_wdata[fpp_pkg::BIT_ERASE_SELECT])) begin
        next_r.write_select = bus_wdata[fpp_pkg::BIT_WRITE_SELECT];
        next_r.erase_select = bus_wdata[fpp_pkg::BIT_ERASE_SELECT];
      end
      next_r.mass_select = bus_wdata[fpp_pkg::BIT_MASS_SELECT];
      if (!hv_req) begin
        next_r.high_voltage_on = 1'b0;
        if (!r.write_select && !r.erase_select) begin
          next_r.st = fpp_pkg::FPP_IDLE;
        end
      end else if (hv_allowed(r.st, sel_ok, r.high_voltage_on,
                              r.protect_start_bits, r.target_addr)) begin
        next_r.high_voltage_on = 1'b1;
        next_r.sweep_cnt       = '0;
        next_r.st = r.erase_select ? fpp_pkg::FPP_SWEEP : fpp_pkg::FPP_ACTIVE;
      end
      // Dropping both selects with high voltage off ends the sequence
      if (!next_r.write_select && !next_r.erase_select && !next_r.high_voltage_on) begin
        next_r.st = fpp_pkg::FPP_IDLE;
      end else if (r.st == fpp_pkg::FPP_IDLE) begin
        next_r.st = fpp_pkg::FPP_ARMED;
      end
    end else if (prot_wr) begin
      // Takes effect on the next set request; a running step is not stopped
      next_r.protect_start_bits = bus_wdata;
    end else if (arr_wr && r.st != fpp_pkg::FPP_SWEEP) begin
      // Sweep owns the write port, so bus writes then are dropped
      if (!r.write_select && !r.erase_select) begin
        next_r.st = r.st;
      end else begin
        if (r.write_select) begin
          next_r.target_addr = bus_addr;
          next_r.target_data = bus_wdata;
        end else if (r.st == fpp_pkg::FPP_ARMED) begin
          next_r.target_addr = bus_addr;
        end
        if (r.st == fpp_pkg::FPP_ARMED) begin
          next_r.setup_cnt = fpp_pkg::CNT_W'(fpp_pkg::SETUP_CYCLES - 1);
          next_r.st        = fpp_pkg::FPP_SETUP;
        end
        // Programming only clears bits; row of the latched target only
        if (r.write_select && r.high_voltage_on && r.st == fpp_pkg::FPP_ACTIVE
            && same_row(bus_addr, r.target_addr)) begin
          mem_we  = 1'b1;
          mem_idx = bus_hit[fpp_pkg::IDX_W-1:0];
          mem_wd  = mem[bus_hit[fpp_pkg::IDX_W-1:0]] & bus_wdata;
        end
      end
    end

    // Pump and array supply follow the enable bit
    // Both from one bit, so the two supplies can never disagree
    next_r.pump = next_r.high_voltage_on;
    next_r.hv   = next_r.high_voltage_on;
  end

  // State register; control cleared and protection open at reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r                    <= '0;
      r.protect_start_bits <= fpp_pkg::PROTECT_RESET;
      r.write_select       <= fpp_pkg::OP_CONTROL_RESET[fpp_pkg::BIT_WRITE_SELECT];
      r.erase_select       <= fpp_pkg::OP_CONTROL_RESET[fpp_pkg::BIT_ERASE_SELECT];
      r.mass_select        <= fpp_pkg::OP_CONTROL_RESET[fpp_pkg::BIT_MASS_SELECT];
      r.high_voltage_on    <= fpp_pkg::OP_CONTROL_RESET[fpp_pkg::BIT_HIGH_VOLTAGE];
      r.st                 <= fpp_pkg::FPP_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // Array write port; contents survive reset like real flash
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      mem[mem_idx] <= mem_wd;
    end
  end

  // Outputs straight from the state register, no logic after the flops
  assign bus_rdata   = r.rdata;
  assign pump_on     = r.pump;
  assign array_hv_on = r.hv;

endmodule

// file: verif/fpp_flash_ctrl_asserts.sv
`timescale 1ns/1ps
module fpp_flash_ctrl_chk (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0]  bus_wdata,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [7:0]  bus_rdata,
  input wire logic        pump_on,
  input wire logic        array_hv_on
);
  logic [7:0] prot;
  logic       ctl_wr;
  logic       ctl_rd;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Control accesses seen on the bus
  assign ctl_wr = bus_wr && bus_addr == fpp_pkg::ADDR_OP_CONTROL;
  assign ctl_rd = bus_rd && bus_addr == fpp_pkg::ADDR_OP_CONTROL;
  // Own copy of the protect value, so refusals can be judged
  always_ff @(posedge sys_clk) begin
    if (rst)
      prot <= fpp_pkg::PROTECT_RESET;
    else if (bus_wr && bus_addr == fpp_pkg::ADDR_PROTECT_START)
      prot <= bus_wdata;
  end
  a_pump_tracks_hv: assert property (pump_on == array_hv_on)
    else $error("pump and array supply differ");
  a_hv_needs_set: assert property ($rose(pump_on) |-> $past(ctl_wr && bus_wdata[3]))
    else $error("high voltage rose without a set request");
  a_hv_one_sel: assert property ($rose(pump_on) |-> $past(bus_wdata[0] ^ bus_wdata[1]))
    else $error("high voltage rose without exactly one select");
  a_hv_all_prot: assert property ($rose(pump_on) |-> prot != 8'h00)
    else $error("high voltage rose while all flash protected");
  a_hv_drop: assert property (ctl_wr && !bus_wdata[3] |=> !pump_on)
    else $error("high voltage stayed on after clear");
  a_sel_exclusive: assert property (ctl_rd |=> !(bus_rdata[0] && bus_rdata[1]))
    else $error("both selects read as one");
  a_prot_readback: assert property (bus_rd && bus_addr == fpp_pkg::ADDR_PROTECT_START
    |=> bus_rdata == prot)
    else $error("protect read back wrong");
  a_hv_bit_pump: assert property (ctl_rd ##1 bus_rdata[3] |-> pump_on)
    else $error("high voltage bit set but pump off");
  c_pump_on: cover property ($rose(pump_on));
  c_ctl_read: cover property (ctl_rd);
  c_prot_zero: cover property (prot == 8'h00);
endmodule
bind fpp_flash_ctrl fpp_flash_ctrl_chk u_chk (.sys_clk(sys_clk), .rst(rst),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .pump_on(pump_on), .array_hv_on(array_hv_on));

// file: verif/fpp_host_model.sv
`timescale 1ns/1ps
module fpp_host_model (
  input  wire logic        sys_clk,
  input  wire logic [7:0]  bus_rdata,
  output logic      [15:0] bus_addr,
  output logic      [7:0]  bus_wdata,
  output logic             bus_wr,
  output logic             bus_rd
);
  localparam logic [15:0] CTL = fpp_pkg::ADDR_OP_CONTROL;
  // Bus quiet at time zero
  initial begin
    bus_addr  = 16'h0000;
    bus_wdata = 8'h00;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
  end
  // Released lines show the inverse, so stale values never look valid
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge sys_clk);
    bus_wr    <= 1'b0;
    bus_addr  <= ~a;
    bus_wdata <= ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge sys_clk);
    bus_rd   <= 1'b0;
    bus_addr <= ~a;
    @(posedge sys_clk);
    d = bus_rdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Whole sequence from RAM code; n is the erase or byte time
  task automatic op(input logic [7:0] sel, input logic [15:0] a, input logic [7:0] d,
                    input int n, output logic hv);
    logic [7:0] v;
    wr(CTL, sel);
    wr(a, d);
    idle(fpp_pkg::SETUP_CYCLES + 5);
    wr(CTL, sel | 8'h08);
    rd(CTL, v);                       // Read back the control register for the high voltage bit
    hv = v[3];
    if (sel[0])
      wr(a, d);
    idle(n);
    wr(CTL, 8'h08);
    idle(sel[2] ? 1000 : 50);         // Long hold only after mass erase
    wr(CTL, 8'h00);
    idle(10);
  endtask
endmodule

// file: verif/test_flash_program_erase_protect.sv
`timescale 1ns/1ps
module test_flash_program_erase_protect;
  localparam logic [15:0] CTL = fpp_pkg::ADDR_OP_CONTROL;
  localparam logic [15:0] PRT = fpp_pkg::ADDR_PROTECT_START;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata;
  logic        bus_wr;
  logic        bus_rd;
  logic [7:0]  bus_rdata;
  logic        pump_on;
  logic        array_hv_on;
  logic        hv;
  int          fails = 0;
  int          checks_done = 0;
  always #50 sys_clk = ~sys_clk;
  fpp_flash_ctrl u_dut (.sys_clk(sys_clk), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .pump_on(pump_on), .array_hv_on(array_hv_on));
  fpp_host_model u_host (.sys_clk(sys_clk), .bus_rdata(bus_rdata), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] v;
    u_host.rd(a, v);
    chk($sformatf("read %h", a), exp, v);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Scenarios, each judging its own results
  task automatic s_interlock;
    rdchk(CTL, fpp_pkg::OP_CONTROL_RESET);
    rdchk(PRT, fpp_pkg::PROTECT_RESET);
    u_host.wr(CTL, 8'h01);
    u_host.wr(CTL, 8'h03);
    rdchk(CTL, 8'h01);
    u_host.wr(CTL, 8'h00);
    u_host.wr(CTL, 8'h03);
    rdchk(CTL, 8'h00);
  endtask
  task automatic s_hv_refused;
    u_host.wr(CTL, 8'h08);
    rdchk(CTL, 8'h00);
    u_host.wr(CTL, 8'h01);
    u_host.idle(110);
    u_host.wr(CTL, 8'h09);
    rdchk(CTL, 8'h01);
    u_host.wr(16'hc100, 8'h00);
    u_host.wr(CTL, 8'h09);
    rdchk(CTL, 8'h01);
    u_host.wr(CTL, 8'h00);
  endtask
  task automatic s_mass_and_idle_write;
    u_host.op(8'h06, 16'hc123, 8'h5a, 40000, hv);
    chk("mass hv", 8'h01, {7'h0, hv});
    chk("pump after", 8'h00, {7'h0, pump_on});
    rdchk(16'hc000, 8'hff);
    rdchk(16'hefff, 8'hff);
    rdchk(16'hffd0, 8'hff);
    u_host.wr(16'hc200, 8'h00);
    rdchk(16'hc200, 8'hff);
  endtask
  task automatic s_pump_live;
    u_host.wr(CTL, 8'h01);
    u_host.wr(16'hc300, 8'hff);
    u_host.idle(fpp_pkg::SETUP_CYCLES + 5);
    u_host.wr(CTL, 8'h09);
    u_host.idle(1);
    chk("pump live", 8'h01, {7'h0, pump_on});
    chk("array hv live", 8'h01, {7'h0, array_hv_on});
    u_host.wr(16'hc300, 8'h7e);
    u_host.wr(16'hc340, 8'h00);
    u_host.wr(CTL, 8'h08);
    u_host.wr(CTL, 8'h00);
    u_host.idle(1);
    chk("pump off", 8'h00, {7'h0, pump_on});
    chk("array hv off", 8'h00, {7'h0, array_hv_on});
    rdchk(16'hc300, 8'h7e);
    rdchk(16'hc340, 8'hff);
  endtask
  task automatic s_program_and_page;
    u_host.op(8'h01, 16'hc040, 8'ha5, 300, hv);
    chk("prog hv", 8'h01, {7'h0, hv});
    u_host.op(8'h01, 16'hc07f, 8'h3c, 300, hv);
    u_host.op(8'h01, 16'hc040, 8'h0f, 300, hv);
    rdchk(16'hc040, 8'h05);
    rdchk(16'hc07f, 8'h3c);
    rdchk(16'hc041, 8'hff);
    u_host.op(8'h01, 16'hc0c0, 8'h11, 300, hv);
    u_host.op(8'h01, 16'hffd0, 8'h00, 300, hv);
    u_host.op(8'h02, 16'hc07f, 8'h00, 10000, hv);
    rdchk(16'hc040, 8'hff);
    rdchk(16'hc0c0, 8'h11);
    u_host.op(8'h02, 16'hffd0, 8'h00, 10000, hv);
    rdchk(16'hffd0, 8'h00);
  endtask
  task automatic s_protect;
    u_host.wr(PRT, 8'h03);
    rdchk(PRT, 8'h03);
    u_host.op(8'h01, 16'hc080, 8'h00, 300, hv);
    chk("hv at start", 8'h00, {7'h0, hv});
    rdchk(16'hc080, 8'hff);
    u_host.op(8'h01, 16'hc07e, 8'h00, 300, hv);
    chk("hv below start", 8'h01, {7'h0, hv});
    u_host.wr(PRT, 8'h00);
    u_host.op(8'h02, 16'hc000, 8'h00, 0, hv);
    chk("hv all protected", 8'h00, {7'h0, hv});
    rdchk(16'hc07e, 8'h00);
    u_host.wr(PRT, 8'hff);
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    s_interlock;
    s_hv_refused;
    s_mass_and_idle_write;
    s_pump_live;
    s_program_and_page;
    s_protect;
    give_verdict;
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    fails++;
    give_verdict;
  end
endmodule
